/* File: rtl/clk_seq_map.svh */
// Offsets-free constant map: field codes, timing figures and derived cycle counts for the clock sequencer.
`ifndef CLK_SEQ_MAP_SVH
`define CLK_SEQ_MAP_SVH
`define CLK_PERIOD_PS 4000
`define SHUTDOWN_LOW_NS 150
`define SHUTDOWN_LOW_CYC (((`SHUTDOWN_LOW_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define LOCK_MCLK_MS 40
`define LOCK_FRAME_MS 160
`define LOCK_BIT_MS 2
`define MS_TO_CYC(ms) (((ms) * 1000000) / (`CLK_PERIOD_PS / 1000))
`define REF_SEL_MCLK 2'h0
`define REF_SEL_FRAME 2'h1
`define REF_SEL_BIT 2'h2
`define PRESENT_TIMEOUT_CYC 256
`define DAC_POS_FULL 16'h7fff
`define DAC_NEG_FULL 16'h8000
`define MCLK_OUT_DIV 2
`endif

/* File: rtl/clk_seq_pkg.sv */
// Types shared by the clock set-up sequencer.
package clk_seq_pkg;
  typedef enum logic [1:0] {ref_mclk, ref_frame, ref_bit, ref_none} ref_src_t;
  typedef struct packed {
    logic [1:0] interface_format_select;
    logic [3:0] sample_rate_select;
    logic [1:0] pll_reference_select;
    logic bit_clock_rate_select;
    logic master_select;
  } clk_cfg_t;
  typedef struct packed {
    logic pll_power_enable;
    logic common_voltage_power;
    logic master_clock_out_enable;
  } clk_pwr_t;
endpackage : clk_seq_pkg

/* File: rtl/codec_clock_setup_sequencer.sv */
// Clock set-up sequencer: reset handling, PLL lock timing, clock gating and master clock generation.
`include "clk_seq_map.svh"

// Notes on behaviour
// - PLL on master clock input locks within 40 ms of power bit rising.
// - In PLL master mode frame and bit clocks start only after lock.
// - Master clock output may be invalid while locking, correct after lock.
// - PLL referenced to frame clock locks within 160 ms.
// - PLL referenced to bit clock locks within 2 ms.
// - In slave modes the PLL starts on power bit rise with reference present.
// - External clock mode runs only when master, frame and bit clocks are present.
// - PLL power bit low selects external clock mode, high selects PLL mode.
// - Frame and bit clock pins stay undriven until master select is one and the PLL is locked.
// - DAC samples are two's complement, 7fff positive and 8000 negative full scale.
module codec_clock_setup_sequencer
  import clk_seq_pkg::*;
#(
  parameter int unsigned LOCK_MCLK_CYC = `MS_TO_CYC(`LOCK_MCLK_MS),
  parameter int unsigned LOCK_FRAME_CYC = `MS_TO_CYC(`LOCK_FRAME_MS),
  parameter int unsigned LOCK_BIT_CYC = `MS_TO_CYC(`LOCK_BIT_MS)
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  input wire logic chip_shutdown_n_in,
  input wire clk_cfg_t cfg_in,
  input wire clk_pwr_t pwr_in,
  input wire logic frame_sync_clock_in,
  input wire logic serial_bit_clock_in,
  input wire logic [15:0] dac_sample_in,
  output logic device_reset_out,
  output logic external_clock_mode_out,
  output logic lock_done_out,
  output logic normal_operation_out,
  output logic master_clock_out,
  output logic frame_sync_clock_out,
  output logic frame_sync_clock_oe_n_out,
  output logic serial_bit_clock_out,
  output logic serial_bit_clock_oe_n_out,
  output logic signed [16:0] dac_level_out
);
  typedef enum logic [2:0] {st_reset, st_idle, st_locking, st_locked, st_external} seq_state_t;

  // Link side: presence toggles on the link clock, crossed as events.
  logic link_tog_reg;
  always_ff @(posedge link_clk_in or posedge reset_in)
  begin
    if (reset_in)
      link_tog_reg <= 1'b0;
    else
      link_tog_reg <= ~link_tog_reg;
  end

  logic [2:0] sh_sync1_reg, sh_sync2_reg, sh_prev_reg;
  logic [1:0] sd_sync_reg;
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sh_sync1_reg <= 3'h0;
      sh_sync2_reg <= 3'h0;
      sh_prev_reg <= 3'h0;
      sd_sync_reg <= 2'h0;
    end
    else
    begin
      sh_sync1_reg <= {link_tog_reg, frame_sync_clock_in, serial_bit_clock_in};
      sh_sync2_reg <= sh_sync1_reg;
      sh_prev_reg <= sh_sync2_reg;
      sd_sync_reg <= {sd_sync_reg[0], chip_shutdown_n_in};
    end
  end

  wire [2:0] edge_seen = sh_sync2_reg ^ sh_prev_reg;
  wire shutdown_n = sd_sync_reg[1];

  // Presence: an edge seen within the timeout window keeps a clock counted present.
  logic [8:0] pres_cnt_reg [3];
  logic [2:0] present;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pres
      always_ff @(posedge clk_in or posedge reset_in)
      begin
        if (reset_in)
          pres_cnt_reg[gi] <= 9'h0;
        else if (edge_seen[gi])
          pres_cnt_reg[gi] <= 9'(`PRESENT_TIMEOUT_CYC);
        else if (pres_cnt_reg[gi] != 9'h0)
          pres_cnt_reg[gi] <= pres_cnt_reg[gi] - 9'h1;
      end
      assign present[gi] = pres_cnt_reg[gi] != 9'h0;
    end
  endgenerate
  wire mclk_present = present[2];
  wire frame_present = present[1];
  wire bit_present = present[0];

  // Shutdown low time is counted so a glitch shorter than the minimum does not reset.
  logic [7:0] low_cnt_reg;
  wire low_long = low_cnt_reg >= 8'(`SHUTDOWN_LOW_CYC);
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      low_cnt_reg <= 8'h0;
    else if (shutdown_n)
      low_cnt_reg <= 8'h0;
    else if (!low_long)
      low_cnt_reg <= low_cnt_reg + 8'h1;
  end

  function automatic logic [31:0] lock_limit(input logic [1:0] sel);
    unique case (sel)
      `REF_SEL_FRAME: lock_limit = LOCK_FRAME_CYC;
      `REF_SEL_BIT: lock_limit = LOCK_BIT_CYC;
      default: lock_limit = LOCK_MCLK_CYC;
    endcase
  endfunction : lock_limit

  function automatic logic ref_ok(input logic [1:0] sel, input logic [2:0] pres);
    unique case (sel)
      `REF_SEL_FRAME: ref_ok = pres[1];
      `REF_SEL_BIT: ref_ok = pres[0];
      default: ref_ok = pres[2];
    endcase
  endfunction : ref_ok

  seq_state_t state_reg, state_next;
  logic [31:0] lock_cnt_reg;
  logic pll_en_prev_reg;
  wire pll_rise = pwr_in.pll_power_enable & ~pll_en_prev_reg;
  wire ref_here = ref_ok(cfg_in.pll_reference_select, present);
  wire all_three = mclk_present & frame_present & bit_present;
  wire lock_expired = lock_cnt_reg >= lock_limit(cfg_in.pll_reference_select);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      st_reset: if (shutdown_n) state_next = st_idle;
      st_idle:
        if (pwr_in.common_voltage_power && !pwr_in.pll_power_enable)
          state_next = st_external;
        else if (pwr_in.common_voltage_power && pll_rise && ref_here)
          state_next = st_locking;
      st_locking:
        if (!pwr_in.pll_power_enable) state_next = st_idle;
        else if (lock_expired) state_next = st_locked;
      st_locked: if (!pwr_in.pll_power_enable) state_next = st_idle;
      // The power bit normally rises while the external path runs, so that rise must start the lock too.
      st_external:
        if (pwr_in.common_voltage_power && pll_rise && ref_here)
          state_next = st_locking;
        else if (pwr_in.pll_power_enable || !pwr_in.common_voltage_power)
          state_next = st_idle;
    endcase
    if (low_long) state_next = st_reset;
  end

  // Master clock output divider, only advancing once the PLL is locked.
  logic [1:0] mdiv_reg;
  wire locked = state_reg == st_locked;
  wire master_mode = cfg_in.master_select & locked;
  wire ext_ok = state_reg == st_external && all_three;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_reg <= st_reset;
      lock_cnt_reg <= 32'h0;
      pll_en_prev_reg <= 1'b0;
      mdiv_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      pll_en_prev_reg <= pwr_in.pll_power_enable;
      lock_cnt_reg <= (state_reg == st_locking) ? lock_cnt_reg + 32'h1 : 32'h0;
      mdiv_reg <= locked ? mdiv_reg + 2'h1 : 2'h0;
    end
  end

  // Bit clock uses the divider's low bit, frame a slower tap; real ratios live in the analog PLL.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      device_reset_out <= 1'b1;
      external_clock_mode_out <= 1'b1;
      lock_done_out <= 1'b0;
      normal_operation_out <= 1'b0;
      master_clock_out <= 1'b0;
      frame_sync_clock_out <= 1'b1;
      frame_sync_clock_oe_n_out <= 1'b1;
      serial_bit_clock_out <= 1'b1;
      serial_bit_clock_oe_n_out <= 1'b1;
      dac_level_out <= 17'sh0;
    end
    else
    begin
      device_reset_out <= state_next == st_reset;
      external_clock_mode_out <= ~pwr_in.pll_power_enable;
      lock_done_out <= state_next == st_locked;
      normal_operation_out <= (state_next == st_locked) | ext_ok;
      master_clock_out <= pwr_in.master_clock_out_enable & locked & mdiv_reg[`MCLK_OUT_DIV - 1];
      frame_sync_clock_out <= master_mode ? mdiv_reg[1] : 1'b1;
      serial_bit_clock_out <= master_mode ? mdiv_reg[0] : 1'b1;
      frame_sync_clock_oe_n_out <= ~master_mode;
      serial_bit_clock_oe_n_out <= ~master_mode;
      dac_level_out <= 17'($signed(dac_sample_in));
    end
  end

  lock_wait_a: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(lock_done_out) |-> $past(state_reg) == st_locking) else $error("lock done without lock wait");
  pins_hiz_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !lock_done_out |-> ##1 frame_sync_clock_oe_n_out && serial_bit_clock_oe_n_out) else $error("clock pins driven early");
  ms_gate_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !serial_bit_clock_oe_n_out |-> $past(cfg_in.master_select)) else $error("pins driven in slave");
  mclk_gate_a: assert property (@(posedge clk_in) disable iff (reset_in)
    master_clock_out |-> $past(locked) && $past(pwr_in.master_clock_out_enable)) else $error("master clock early");
  ext_mode_a: assert property (@(posedge clk_in) disable iff (reset_in)
    external_clock_mode_out == !$past(pwr_in.pll_power_enable)) else $error("mode bit mismatch");
  ext_clocks_a: assert property (@(posedge clk_in) disable iff (reset_in)
    normal_operation_out && external_clock_mode_out |-> $past(all_three)) else $error("ext run without clocks");
  lock_start_a: assert property (@(posedge clk_in) disable iff (reset_in)
    state_reg != st_locking ##1 state_reg == st_locking |-> $past(ref_here)) else $error("lock without reference");
  dac_scale_a: assert property (@(posedge clk_in) disable iff (reset_in)
    dac_sample_in == `DAC_NEG_FULL |=> dac_level_out == -17'sd32768) else $error("dac sign wrong");
  shut_reset_a: assert property (@(posedge clk_in) disable iff (reset_in)
    low_long |=> device_reset_out) else $error("no reset after long low");
  lock_cov_c: cover property (@(posedge clk_in) disable iff (reset_in) $rose(lock_done_out));
  ext_cov_c: cover property (@(posedge clk_in) disable iff (reset_in) ext_ok);
  master_cov_c: cover property (@(posedge clk_in) disable iff (reset_in) $fell(serial_bit_clock_oe_n_out));
endmodule : codec_clock_setup_sequencer

/* File: bench/host_clock_model.sv */
// Host-side clock source that feeds master, bit and frame clocks to the sequencer.
module host_clock_model (
  input wire logic run_in,
  output logic link_clk_out,
  output logic frame_out,
  output logic bit_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt_reg = 5'h0;
  initial link_clk_out = 1'b0;
  // A stopped host holds its clocks still, so the presence detectors must time out.
  always #7.5 link_clk_out = run_in ? ~link_clk_out : link_clk_out;
  // Bit and frame clocks are divided from the master clock so that they stay in step with it.
  always @(posedge link_clk_out) cnt_reg <= cnt_reg + 5'h1;
  assign bit_out = cnt_reg[0];
  assign frame_out = cnt_reg[4];
endmodule : host_clock_model

/* File: bench/codec_clock_setup_sequencer_test.sv */
// Self-checking bench for the clock set-up sequencer.
module codec_clock_setup_sequencer_test;
  import clk_seq_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, reset_in = 1'b1, shut_n = 1'b0, run = 1'b1;
  clk_cfg_t cfg = '0;
  clk_pwr_t pwr = '0;
  logic [15:0] smp = 16'h0;
  logic rst_o, ext_o, lock_o, norm_o, mclk_o, fr_o, fr_oe_n, bt_o, bt_oe_n, lk, fr, bt;
  logic signed [16:0] lvl;
  int fails = 0, cmp_count = 0, lim[3] = '{50, 80, 20};
  logic [31:0] seed = 32'h84844edf;
  always #2 clk_in = ~clk_in;
  host_clock_model part_u (.run_in(run), .link_clk_out(lk), .frame_out(fr), .bit_out(bt));
  codec_clock_setup_sequencer #(.LOCK_MCLK_CYC(50), .LOCK_FRAME_CYC(80), .LOCK_BIT_CYC(20)) dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .link_clk_in(lk), .chip_shutdown_n_in(shut_n), .cfg_in(cfg),
    .pwr_in(pwr), .frame_sync_clock_in(fr), .serial_bit_clock_in(bt), .dac_sample_in(smp),
    .device_reset_out(rst_o), .external_clock_mode_out(ext_o), .lock_done_out(lock_o),
    .normal_operation_out(norm_o), .master_clock_out(mclk_o), .frame_sync_clock_out(fr_o),
    .frame_sync_clock_oe_n_out(fr_oe_n), .serial_bit_clock_out(bt_o), .serial_bit_clock_oe_n_out(bt_oe_n),
    .dac_level_out(lvl));
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(string nm, logic [16:0] exp, logic [16:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic tally_and_finish;
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic lock_run(logic [1:0] rs, logic ms);
    int n;
    logic t;
    @(posedge clk_in) cfg <= '{2'h1, 4'h8, rs, 1'b1, ms};
    tick(2);
    @(posedge clk_in) pwr <= '{1'b0, 1'b1, 1'b1};
    tick(4);
    chk("lock_idle", 1'b0, lock_o);
    @(posedge clk_in) pwr.pll_power_enable <= 1'b1;
    n = 0;
    tick(1);
    while (lock_o !== 1'b1 && n < 200)
    begin
      chk("oe_early", 2'h3, {fr_oe_n, bt_oe_n});
      chk("mclk_early", 1'b0, mclk_o);
      n++;
      tick(1);
    end
    chk("lock_time", 1'b1, n >= lim[rs] && n <= lim[rs] + 4);
    tick(1);
    chk("normal", 1'b1, norm_o);
    chk("ext_mode", 1'b0, ext_o);
    chk("oe_lock", {~ms, ~ms}, {fr_oe_n, bt_oe_n});
    t = mclk_o;
    n = 0;
    repeat (8)
    begin
      tick(1);
      n += (mclk_o !== t);
      t = mclk_o;
    end
    chk("mclk_run", 1'b1, n > 0);
    @(posedge clk_in) pwr.pll_power_enable <= 1'b0;
    tick(3);
    chk("unlock", 1'b0, lock_o);
  endtask : lock_run
  initial
  begin
    tick(1);
    chk("rst_vals", 9'h1f8, {rst_o, ext_o, fr_oe_n, bt_oe_n, fr_o, bt_o, lock_o, norm_o, mclk_o});
    @(posedge clk_in) reset_in <= 1'b0;
    tick(40);
    chk("held", 1'b1, rst_o);
    @(posedge clk_in) shut_n <= 1'b1;
    tick(8);
    chk("released", 1'b0, rst_o);
    foreach (lim[i]) lock_run(i[1:0], i == 0);
    tick(4);
    chk("ext_on", 2'h3, {ext_o, norm_o});
    @(posedge clk_in) run <= 1'b0;
    tick(300);
    chk("ext_noclk", 1'b0, norm_o);
    @(posedge clk_in) cfg.pll_reference_select <= 2'h1;
    @(posedge clk_in) pwr.pll_power_enable <= 1'b1;
    tick(120);
    chk("no_ref", 1'b0, lock_o);
    for (int i = 0; i < 22; i++)
    begin
      seed = xs(seed);
      @(posedge clk_in) smp <= (i == 0) ? 16'h7fff : (i == 1) ? 16'h8000 : seed[15:0];
      tick(2);
      chk("dac", {smp[15], smp}, lvl);
    end
    tally_and_finish;
  end
  initial
  begin
    #20000;
    fails++;
    tally_and_finish;
  end
endmodule : codec_clock_setup_sequencer_test
